// ===== rtl/pmc_pkg.sv
/*
  Package of the power mode control block: register map, field positions,
  reset values, pin-state structs and the block's state type.
  Assumes a single 100 MHz clock domain and a 32-bit Avalon-MM slave port.
*/
package pmc_pkg;

  // ****************************************************************
  // Register map (byte addresses)
  // ****************************************************************
  localparam logic [3:0] PMC_OFS_POWER_CONTROL = 4'h0; // Power control byte
  localparam logic [3:0] PMC_OFS_STATUS        = 4'h4; // Block state, read only
  localparam logic [3:0] PMC_OFS_SERIAL_TOP    = 4'h8; // Routed serial control bit 7

  // ****************************************************************
  // Power control field positions
  // ****************************************************************
  localparam int PMC_BIT_BAUD_DOUBLER   = 7;
  localparam int PMC_BIT_FRAMING_SELECT = 6;
  localparam int PMC_BIT_RESERVED       = 5;
  localparam int PMC_BIT_COLD_START     = 4;
  localparam int PMC_BIT_USER_ONE       = 3;
  localparam int PMC_BIT_USER_ZERO      = 2;
  localparam int PMC_BIT_POWER_DOWN     = 1;
  localparam int PMC_BIT_SLEEP          = 0;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0] PMC_POWER_CONTROL_RST = 8'h10; // Cold start set, rest zero
  localparam logic [7:0] PMC_WARM_KEEP_MASK    = 8'h10; // Cold start survives warm reset
  localparam logic       PMC_SERIAL_BIT_RST    = 1'h0;  // Both routed bits clear

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    PMC_RUN,
    PMC_IDLE,
    PMC_POWER_DOWN,
    PMC_WAKE_HOLD
  } pmc_mode_t;

  // Pin states forced in emulation, plus the crystal oscillator run bit
  typedef struct packed {
    logic strobe_pullup;   // Both strobes weakly pulled high
    logic port0_float;     // Port 0 released
    logic port123_pullup;  // Ports 1..3 weakly pulled high
    logic osc_run;         // Crystal oscillator enabled
  } pmc_pins_t;

  typedef struct packed {
    logic [7:0] power_control;
    logic       serial_mode_bit_zero;
    logic       framing_error_flag;
    pmc_mode_t  mode;
    logic       emulation;
    logic       watchdog_run;
    logic       wake_irq;
    logic       rst_seen;
    logic [2:0] strobe_sync;
    logic [2:0] irq_sync;
    logic [1:0] pss_sync;
    logic [1:0] hwrst_sync;
    logic       ack;
    logic [31:0] rdata;
    pmc_pins_t  pins;
  } pmc_state_t;

endpackage

// ===== rtl/pmc_power_mode_control.sv
/*
  Power mode control: power control register, idle and power-down sequencing,
  watchdog run gating, cold-start flag and on-chip emulation entry.
  Assumes: resetn is the power-on reset (supply rising), hw_reset_n is the
  warm reset pin, ext_irq_n is a level external interrupt, all pins async.
*/
// Decided for this implementation: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps

// Function
// - Power-down stops watchdog counter, and oscillator outside emulation
// - Leave power-down on reset or enabled level interrupt
// - Service power-down wake interrupt only after line high; idle wake serviced while line low
// - Watchdog halted while wake interrupt stays low
// - Idle keeps oscillator and watchdog running
// - Strobe low with program strobe high sampled at reset release enters emulation
// - Emulation pulls up strobes, ports, floats port zero
// - Only normal reset leaves emulation
// - Cold-start flag bit 4 set at power-on
// - Software sets and clears cold-start flag
// - Bit 6 routes serial top bit
// - Bit 5 reserved, never written one
// - Bits 3 and 2 plain user flags
// - Bit 1 enters power-down, reset clears it
// - Bit 0 enters idle, interrupt or reset clears
// - Reset pattern cold-start set, others zero
module pmc_power_mode_control
  import pmc_pkg::*;
(
  input  wire logic        mclk,               // 100 MHz clock
  input  wire logic        resetn,             // Power-on reset, async, low
  input  wire logic        clk_en,             // Freezes all state when low
  // Avalon-MM slave
  input  wire logic [3:0]  avs_address,        // Byte address
  input  wire logic        avs_read,           // Read request
  input  wire logic        avs_write,          // Write request
  input  wire logic [31:0] avs_writedata,      // Write data
  input  wire logic [3:0]  avs_byteenable,     // Byte lanes
  output logic      [31:0] avs_readdata,       // Read data
  output logic             avs_waitrequest,    // Low for the answer cycle
  // Pins and neighbours
  input  wire logic        hw_reset_n,         // Warm reset pin, low active
  input  wire logic        ext_irq_n,          // Level external interrupt, low active
  input  wire logic        ext_irq_enable,     // Interrupt enabled, same clock
  input  wire logic        addr_strobe_n_in,   // Address latch strobe pin level
  input  wire logic        program_store_strobe_in, // Program store strobe pin level
  input  wire logic        frame_error_set,    // Serial receiver framing error pulse
  output logic             baud_doubler,       // Serial baud rate doubled
  output logic             cpu_halt,           // Core clock stopped (idle, power-down or wake hold)
  output logic             osc_enable,         // Crystal oscillator running
  output logic             watchdog_run,       // Watchdog counter may count
  output logic             wake_irq_service,   // Pulse: service wake interrupt
  output logic             emulation_mode,     // Emulation mode active
  output pmc_pins_t        emu_pins            // Pin states forced in emulation
);

  // ****************************************************************
  // State
  // ****************************************************************
  pmc_state_t s_q;  // Every flip-flop of the block
  pmc_state_t s_d;  // Next value

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb begin
    logic       wr_hit;    // Accepted write
    logic       rd_hit;    // Accepted read
    logic [7:0] wb;        // Low write byte, for the power control and serial top registers
    logic       irq_low;   // Synchronised interrupt level, high while the line is low
    logic       warm_rst;  // Synchronised warm reset held
    logic       rst_rel;   // Warm reset released this cycle
    s_d      = s_q;
    wb       = avs_writedata[7:0];
    irq_low  = ~s_q.irq_sync[1];
    warm_rst = ~s_q.hwrst_sync[1];
    rst_rel  = s_q.rst_seen & ~warm_rst;
    wr_hit   = avs_write & ~s_q.ack;
    rd_hit   = avs_read & ~s_q.ack;

    // Input synchronisers: stage 0 is read only by stage 1
    s_d.irq_sync   = {s_q.irq_sync[1], s_q.irq_sync[0], ext_irq_n};
    s_d.strobe_sync = {s_q.strobe_sync[1], s_q.strobe_sync[0], addr_strobe_n_in};
    s_d.pss_sync   = {s_q.pss_sync[0], program_store_strobe_in};
    s_d.hwrst_sync = {s_q.hwrst_sync[0], hw_reset_n};
    s_d.wake_irq   = 1'b0;
    s_d.ack        = wr_hit | rd_hit;

    // Framing flag: set by the receiver, set wins over a software clear
    if (frame_error_set) begin
      s_d.framing_error_flag = 1'b1;
    end

    // Register writes, one cycle answer
    if (wr_hit && avs_byteenable[0]) begin
      if (avs_address == PMC_OFS_POWER_CONTROL) begin
        s_d.power_control = wb;
        s_d.power_control[PMC_BIT_RESERVED] = 1'b0;
        if (s_q.power_control[PMC_BIT_SLEEP]) begin
          s_d.power_control[PMC_BIT_SLEEP] = 1'b1;
        end
      end else if (avs_address == PMC_OFS_SERIAL_TOP) begin
        if (s_q.power_control[PMC_BIT_FRAMING_SELECT]) begin
          s_d.framing_error_flag = wb[0] | frame_error_set;
        end else begin
          s_d.serial_mode_bit_zero = wb[0];
        end
      end
    end

    // Register reads
    if (rd_hit) begin
      case (avs_address)
        PMC_OFS_POWER_CONTROL: s_d.rdata = {24'h000000, s_q.power_control};
        PMC_OFS_STATUS:        s_d.rdata = {27'h0000000, s_q.watchdog_run,
                                            s_q.emulation, s_q.wake_irq, s_q.mode};
        PMC_OFS_SERIAL_TOP:    s_d.rdata = {31'h00000000,
                                            s_q.power_control[PMC_BIT_FRAMING_SELECT] ?
                                            s_q.framing_error_flag :
                                            s_q.serial_mode_bit_zero};
        default:               s_d.rdata = 32'h00000000;        // Unmapped reads zero
      endcase
    end

    // Power mode sequencing
    case (s_q.mode)
      PMC_RUN: begin
        if (s_q.power_control[PMC_BIT_POWER_DOWN]) begin
          s_d.mode = PMC_POWER_DOWN;
        end else if (s_q.power_control[PMC_BIT_SLEEP]) begin
          s_d.mode = PMC_IDLE;
        end
      end
      PMC_IDLE: begin
        // Oscillator and watchdog keep running; an enabled external interrupt wakes
        if (irq_low && ext_irq_enable) begin
          s_d.power_control[PMC_BIT_SLEEP] = 1'b0;
          s_d.mode = PMC_RUN;
          s_d.wake_irq = 1'b1;
        end
      end
      PMC_POWER_DOWN: begin
        // An enabled level interrupt wakes here, a warm reset below; edge sources are off
        if (irq_low && ext_irq_enable) begin
          s_d.mode = PMC_WAKE_HOLD;
        end
      end
      PMC_WAKE_HOLD: begin
        // Oscillator restarts; line held low by the partner
        if (!irq_low) begin
          s_d.mode = PMC_RUN;
          s_d.power_control[PMC_BIT_POWER_DOWN] = 1'b0;
          s_d.power_control[PMC_BIT_SLEEP] = 1'b0;
          s_d.wake_irq = 1'b1;
        end
      end
      default: s_d.mode = PMC_RUN;
    endcase

    // Watchdog gating: stopped in power-down and during the wake hold
    s_d.watchdog_run = (s_d.mode == PMC_RUN) || (s_d.mode == PMC_IDLE);

    // Warm reset: clears mode bits, keeps cold-start flag and emulation
    // sampling waits for release so the strobe level is caught then
    s_d.rst_seen = warm_rst;
    if (warm_rst) begin
      s_d.power_control = (s_q.power_control & PMC_WARM_KEEP_MASK);
      s_d.mode          = PMC_RUN;
      s_d.watchdog_run  = 1'b0;
      s_d.emulation     = 1'b0;
      s_d.serial_mode_bit_zero = PMC_SERIAL_BIT_RST;
      s_d.framing_error_flag   = PMC_SERIAL_BIT_RST;
    end else if (rst_rel) begin
      // Strobe still low with program strobe high at release
      s_d.emulation = ~s_q.strobe_sync[1] & s_q.pss_sync[1];
      s_d.watchdog_run = 1'b1;
    end

    // Emulation pin states
    s_d.pins.strobe_pullup  = s_d.emulation;
    s_d.pins.port0_float    = s_d.emulation;
    s_d.pins.port123_pullup = s_d.emulation;
    s_d.pins.osc_run        = s_d.emulation | (s_d.mode != PMC_POWER_DOWN);
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  // Power-on reset loads the cold-start pattern; a warm reset does not
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      s_q                      <= '0;
      s_q.power_control        <= PMC_POWER_CONTROL_RST;
      s_q.mode                 <= PMC_RUN;
      s_q.watchdog_run         <= 1'b1;
      s_q.irq_sync             <= 3'h7;
      s_q.strobe_sync          <= 3'h7;
      s_q.pss_sync             <= 2'h3;
      s_q.hwrst_sync           <= 2'h3;
      s_q.pins.osc_run         <= 1'b1;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  // ****************************************************************
  // Outputs straight from flip-flops, avs_waitrequest inverted from ack, cpu_halt decoded from the mode
  // ****************************************************************
  assign avs_readdata     = s_q.rdata;
  assign avs_waitrequest  = ~s_q.ack;
  assign baud_doubler     = s_q.power_control[PMC_BIT_BAUD_DOUBLER];
  assign cpu_halt         = (s_q.mode != PMC_RUN);
  assign osc_enable       = s_q.pins.osc_run;
  assign watchdog_run     = s_q.watchdog_run;
  assign wake_irq_service = s_q.wake_irq;
  assign emulation_mode   = s_q.emulation;
  assign emu_pins         = s_q.pins;

endmodule

// ===== verification/pmc_chk.sv
/* Port checker of the power mode control block.
   Assumes one clock, resetn async low, clk_en dropped for one cycle by the bench. */
`timescale 1ns/1ps
module pmc_chk
  import pmc_pkg::*;
(
  input wire logic      mclk,
  input wire logic      resetn,
  input wire logic      clk_en,
  input wire logic      avs_read,
  input wire logic      avs_write,
  input wire logic      avs_waitrequest,
  input wire logic      hw_reset_n,
  input wire logic      ext_irq_n,
  input wire logic      cpu_halt,
  input wire logic      osc_enable,
  input wire logic      watchdog_run,
  input wire logic      wake_irq_service,
  input wire logic      emulation_mode,
  input wire pmc_pins_t emu_pins
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  // Interrupt line held low, and warm reset seen within three edges
  sequence s_irq_low; (ext_irq_n == 1'b0) [*4]; endsequence
  sequence s_hw_seen;
    !$past(hw_reset_n) || !$past(hw_reset_n, 2) || !$past(hw_reset_n, 3);
  endsequence
  property p_pd_stop; !osc_enable |-> !watchdog_run && cpu_halt; endproperty
  a_pd_stop: assert property (p_pd_stop) else $error("watchdog runs with oscillator off");
  property p_wd_hold; (s_irq_low ##0 !watchdog_run) |=> !watchdog_run; endproperty
  a_wd_hold: assert property (p_wd_hold) else $error("watchdog resumed while line low");
  property p_wake_pulse; wake_irq_service |=> !wake_irq_service; endproperty
  a_wake_pulse: assert property (p_wake_pulse) else $error("service pulse too long");
  property p_emu_pins; emulation_mode && $past(emulation_mode) |-> emu_pins == 4'hF; endproperty
  a_emu_pins: assert property (p_emu_pins) else $error("emulation pin states wrong");
  property p_emu_osc; emulation_mode |-> osc_enable; endproperty
  a_emu_osc: assert property (p_emu_osc) else $error("oscillator off in emulation");
  property p_emu_exit; $fell(emulation_mode) |-> s_hw_seen or !$past(hw_reset_n, 4); endproperty
  a_emu_exit: assert property (p_emu_exit) else $error("emulation left without reset");
  property p_bus_answer; (avs_read || avs_write) && avs_waitrequest && clk_en |=> !avs_waitrequest;
  endproperty
  a_bus_answer: assert property (p_bus_answer) else $error("no answer one cycle after request");
  property p_bus_single; !avs_waitrequest && clk_en |=> avs_waitrequest; endproperty
  a_bus_single: assert property (p_bus_single) else $error("answer longer than one cycle");
endmodule
bind pmc_power_mode_control pmc_chk u_chk (.mclk, .resetn, .clk_en, .avs_read, .avs_write,
  .avs_waitrequest, .hw_reset_n, .ext_irq_n, .cpu_halt, .osc_enable, .watchdog_run,
  .wake_irq_service, .emulation_mode, .emu_pins);

// ===== verification/pmc_emulator.sv
/* Emulator on the pins: warm reset, strobes and wake interrupt.
   Assumes the bench calls its tasks; idle lines rest at their pull-up level. */
`timescale 1ns/1ps
module pmc_emulator (
  input  wire logic mclk,
  input  wire logic osc_enable,
  output logic      hw_reset_n,
  output logic      strobe_n,
  output logic      pss,
  output logic      irq_n
);
  initial begin
    hw_reset_n = 1'b1;
    strobe_n = 1'b1;
    pss = 1'b1;
    irq_n = 1'b1;
  end
  // Warm reset with chosen strobe levels, strobe held past release
  task reset_pulse(input logic s_n, input logic p);
    @(posedge mclk);
    hw_reset_n <= 1'b0;
    strobe_n <= s_n;
    pss <= p;
    repeat (8) @(posedge mclk);
    hw_reset_n <= 1'b1;
    repeat (8) @(posedge mclk);
    strobe_n <= 1'b1;
    pss <= 1'b1;
  endtask
  // Line held low until the oscillator has run eight cycles
  task irq_low();
    int n;
    n = 0;
    @(posedge mclk);
    irq_n <= 1'b0;
    while (osc_enable !== 1'b1 && n < 100) begin
      @(posedge mclk);
      n++;
    end
    repeat (8) @(posedge mclk);
  endtask
  task irq_high();
    @(posedge mclk);
    irq_n <= 1'b1;
  endtask
endmodule

// ===== verification/pmc_power_mode_control_test.sv
/* Self-checking bench of the power mode control block.
   Assumes the emulator model and the bound checker. */
`timescale 1ns/1ps
module pmc_power_mode_control_test
  import pmc_pkg::*;
;
  logic        mclk, resetn, clk_en, rd, wr, irq_en, fe_set, wq, baud, halt, osc, wd, svc, emu;
  logic        hw_n, s_n, pss, irq_n;
  logic [3:0]  addr, be, be_v;
  logic [31:0] wdat, rdat;
  logic [7:0]  q;
  pmc_pins_t   pins;
  int          err_count, check_count;
  localparam logic [3:0] PC = PMC_OFS_POWER_CONTROL;
  localparam logic [3:0] SR = PMC_OFS_SERIAL_TOP;
  always #5 mclk = ~mclk;
  pmc_emulator u_emu (.mclk, .osc_enable(osc), .hw_reset_n(hw_n), .strobe_n(s_n), .pss, .irq_n);
  pmc_power_mode_control u_dut (.mclk, .resetn, .clk_en, .avs_address(addr), .avs_read(rd),
    .avs_write(wr), .avs_writedata(wdat), .avs_byteenable(be), .avs_readdata(rdat),
    .avs_waitrequest(wq), .hw_reset_n(hw_n), .ext_irq_n(irq_n), .ext_irq_enable(irq_en),
    .addr_strobe_n_in(s_n), .program_store_strobe_in(pss), .frame_error_set(fe_set),
    .baud_doubler(baud), .cpu_halt(halt), .osc_enable(osc), .watchdog_run(wd),
    .wake_irq_service(svc), .emulation_mode(emu), .emu_pins(pins));
  task close_out();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task chk(input logic [7:0] g, input logic [7:0] e);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // One bus cycle, held until waitrequest is sampled low
  task bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    {addr, wdat, wr, rd, be} <= {a, 24'h0, d, w, !w, be_v};
    do begin
      @(posedge mclk);
      n++;
    end while (wq !== 1'b0 && n < 50);
    if (n >= 50) begin
      err_count++;
      close_out();
    end
    q = rdat[7:0];
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task t_regs();
    bus(0, PC, 0); chk(q, 8'h10);
    bus(1, PC, 8'h2C); bus(0, PC, 0); chk(q, 8'h0C);
    be_v = 4'h0; bus(1, PC, 8'h1C); be_v = 4'hF; bus(0, PC, 0); chk(q, 8'h0C);
    bus(1, PC, 8'h10); bus(0, PC, 0); chk(q, 8'h10);
    bus(0, 4'hC, 8'h00); chk(q, 8'h00);
  endtask
  task t_serial();
    bus(1, PC, 8'h80); cyc(2); chk(baud, 1);
    bus(1, SR, 8'h01); bus(0, SR, 0); chk(q, 1);
    bus(1, PC, 8'h40); bus(0, SR, 0); chk(q, 0);
    clk_en <= 1'b0; fe_set <= 1'b1; cyc(1); {clk_en, fe_set} <= 2'b10;
    bus(0, SR, 0); chk(q, 0);
    fe_set <= 1'b1; cyc(1); fe_set <= 1'b0; bus(0, SR, 0); chk(q, 1);
    bus(1, PC, 8'h10);
  endtask
  task t_idle();
    irq_en <= 1'b1;
    bus(1, PC, 8'h11); cyc(3); chk({halt, osc, wd}, 3'h7);
    bus(1, PC, 8'h10); bus(0, PC, 0); chk(q, 8'h11);
    u_emu.irq_low(); chk(halt, 0); u_emu.irq_high();
    cyc(4); bus(0, PC, 0); chk(q, 8'h10);
  endtask
  task t_pd();
    int n;
    irq_en <= 1'b0;
    bus(1, PC, 8'h12); cyc(4); chk({halt, osc, wd}, 3'h4);
    bus(0, PMC_OFS_STATUS, 0); chk(q, 8'h02);
    u_emu.irq_low(); chk(osc, 0); u_emu.irq_high(); cyc(4);
    irq_en <= 1'b1;
    u_emu.irq_low(); chk({osc, wd, svc}, 3'h4); u_emu.irq_high();
    n = 0;
    while (svc !== 1'b1 && n < 20) begin
      cyc(1);
      n++;
    end
    chk(n < 20, 1); cyc(2); chk({halt, wd}, 2'h1);
    bus(0, PC, 0); chk(q, 8'h10);
  endtask
  task t_emu();
    bus(1, PC, 8'h12); u_emu.reset_pulse(0, 0); chk(emu, 0);
    bus(0, PC, 0); chk(q, 8'h10);
    u_emu.reset_pulse(0, 1); chk({emu, pins, osc}, 8'h3F);
    cyc(20); chk(emu, 1); u_emu.reset_pulse(1, 1); chk(emu, 0);
  endtask
  initial begin
    {mclk, resetn, clk_en, rd, wr, irq_en, fe_set} = 7'h10;
    {addr, wdat, be, be_v} = {36'h0, 8'hFF};
    err_count = 0;
    check_count = 0;
    cyc(16);
    resetn <= 1'b1;
    t_regs();
    t_serial();
    t_idle();
    t_pd();
    t_emu();
    close_out();
  end
endmodule
